/* inc/sad_pkg.sv */
`default_nettype none

package sad_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int PROD_W = 2 * DATA_W;
    localparam int MSB    = DATA_W - 1;
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [APB_AW-1:0] ADDR_TOP   = 8'h00;
    localparam logic [APB_AW-1:0] ADDR_NEXT  = 8'h04;
    localparam logic [APB_AW-1:0] ADDR_PHIGH = 8'h08;
    localparam logic [APB_AW-1:0] ADDR_PLOW  = 8'h0c;
    localparam logic [APB_AW-1:0] ADDR_STAT  = 8'h10;

    // Status word fields
    localparam int STAT_CARRY_BIT = 0;
    localparam int STAT_INTB_BIT  = 1;
    localparam int STAT_SP_LSB    = 8;

    // Reset values
    localparam logic [DATA_W-1:0] WORD_RST  = 16'h0000;
    localparam logic              CARRY_RST = 1'b0;

    // ------------------------------------------------------------------
    // Instruction variants presented by the decoder
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_INV_SHIFT = 4'h0,
        OP_ALU       = 4'h1,
        OP_INV_POP   = 4'h2,
        OP_NTOT_POP  = 4'h3,
        OP_ALU_POP   = 4'h4,
        OP_TTON      = 4'h5,
        OP_SWAP      = 4'h6,
        OP_ALU_TTON  = 4'h7,
        OP_PUSH_COPY = 4'h8,
        OP_PUSH_SWAP = 4'h9,
        OP_PUSH_ALU  = 4'ha,
        OP_UNSIGNED_PRODUCT_OP      = 4'hb,
        OP_SIGNED_PRODUCT_OP      = 4'hc,
        OP_RD_HIGH   = 4'hd,
        OP_RD_LOW    = 4'he,
        OP_NTOT      = 4'hf
    } sad_op_t;

    // ALU combine functions
    typedef enum logic [3:0] {
        ALU_T     = 4'h0,
        ALU_AND   = 4'h1,
        ALU_NSUBT = 4'h2,
        ALU_OR    = 4'h3,
        ALU_ADD   = 4'h4,
        ALU_XOR   = 4'h5,
        ALU_TSUBN = 4'h6,
        ALU_N     = 4'h7
    } sad_alu_t;

    // Shift selections
    typedef enum logic [3:0] {
        SH_NONE = 4'h0, SH_SIGN = 4'h1, SH_SHL  = 4'h2, SH_ROL  = 4'h3,
        SH_CSHR = 4'h4, SH_CROR = 4'h5, SH_LSR  = 4'h6, SH_ASR  = 4'h7,
        SH_NSHL = 4'h8, SH_NROL = 4'h9, SH_DSHL = 4'ha, SH_DROL = 4'hb,
        SH_DCSR = 4'hc, SH_DCRR = 4'hd, SH_DLSR = 4'he, SH_DASR = 4'hf
    } sad_shift_t;

endpackage

`default_nettype wire

/* inc/sad_shift_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface sad_shift_if;
    import sad_pkg::*;

    logic [DATA_W-1:0] zIn;
    logic [DATA_W-1:0] nIn;
    logic              cIn;
    sad_shift_t        sel;
    logic [DATA_W-1:0] tOut;
    logic [DATA_W-1:0] nOut;
    logic              cOut;

    modport user (output zIn, nIn, cIn, sel, input tOut, nOut, cOut);
    modport unit (input zIn, nIn, cIn, sel, output tOut, nOut, cOut);

endinterface

`default_nettype wire

/* logic/sad_shifter.sv */
`timescale 1ns/1ps
`default_nettype none

module sad_shifter (
    sad_shift_if.unit sh
);
    import sad_pkg::*;

    always_comb begin
        sh.tOut = sh.zIn;
        sh.nOut = sh.nIn;
        sh.cOut = sh.cIn;
        case (sh.sel)
            SH_NONE: begin
                sh.tOut = sh.zIn;
            end
            SH_SIGN: sh.tOut = {DATA_W{sh.zIn[MSB]}};
            SH_SHL:  {sh.cOut, sh.tOut} = {sh.zIn, 1'b0};
            SH_ROL:  {sh.cOut, sh.tOut} = {sh.zIn, sh.cIn};
            SH_CSHR: begin
                sh.cOut = 1'b0;
                sh.tOut = {sh.cIn, sh.zIn[MSB:1]};
            end
            SH_CROR: begin
                sh.cOut = sh.zIn[0];
                sh.tOut = {sh.cIn, sh.zIn[MSB:1]};
            end
            SH_LSR: begin
                sh.cOut = 1'b0;
                sh.tOut = {1'b0, sh.zIn[MSB:1]};
            end
            SH_ASR: begin
                sh.cOut = sh.zIn[MSB];
                sh.tOut = {sh.zIn[MSB], sh.zIn[MSB:1]};
            end
            SH_NSHL: sh.nOut = {sh.nIn[MSB-1:0], 1'b0};
            SH_NROL: sh.nOut = {sh.nIn[MSB-1:0], sh.cIn};
            SH_DSHL: {sh.cOut, sh.tOut, sh.nOut} = {sh.zIn, sh.nIn, 1'b0};
            SH_DROL: {sh.cOut, sh.tOut, sh.nOut} = {sh.zIn, sh.nIn, sh.cIn};
            SH_DCSR: begin
                sh.cOut = 1'b0;
                {sh.tOut, sh.nOut} = {sh.cIn, sh.zIn, sh.nIn[MSB:1]};
            end
            SH_DCRR: begin
                sh.cOut = sh.nIn[0];
                {sh.tOut, sh.nOut} = {sh.cIn, sh.zIn, sh.nIn[MSB:1]};
            end
            SH_DLSR: begin
                sh.cOut = 1'b0;
                {sh.tOut, sh.nOut} = {1'b0, sh.zIn, sh.nIn[MSB:1]};
            end
            SH_DASR: begin
                sh.cOut = sh.zIn[MSB];
                {sh.tOut, sh.nOut} = {sh.zIn[MSB], sh.zIn, sh.nIn[MSB:1]};
            end
            default: sh.tOut = sh.zIn;
        endcase
    end

endmodule

`default_nettype wire

/* logic/sad_stack_alu.sv */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - ALU op: shifted result to top
// - Complement-shift top, pop stack into next
// - Next to top, shift, pop into next
// - ALU op shifted to top, pop next
// - Copy top to next, shift top
// - Swap top and next, shift new top
// - ALU op to top, old top to next
// - Push next, copy top, shift top
// - Push next, exchange, shift new top
// - Push next, top to next, ALU top
// - Unsigned multiply into product registers
// - Signed multiply into product registers
// - Multiply and product reads block interrupts
// - Read high product: top, old top next
// - Read low product: top, old top next
// - Shift code zero passes, carry kept unless an ALU add or subtract sets it
// - No complement, no shift: no-operation
module sad_stack_alu #(
    parameter int STACK_DEPTH = 16
) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic                     instValid,
    input  wire sad_pkg::sad_op_t         instOp,
    input  wire sad_pkg::sad_alu_t        aluSel,
    input  wire sad_pkg::sad_shift_t      shiftSel,
    input  wire logic                     invert,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [sad_pkg::APB_AW-1:0] paddr,
    input  wire logic [sad_pkg::APB_DW-1:0] pwdata,
    output logic      [sad_pkg::APB_DW-1:0] prdata,
    output logic                          pready,
    output logic                          pslverr,
    output logic      [sad_pkg::DATA_W-1:0] topOut,
    output logic      [sad_pkg::DATA_W-1:0] nextOut,
    output logic                          carryOut,
    output logic      [sad_pkg::DATA_W-1:0] prodHighOut,
    output logic      [sad_pkg::DATA_W-1:0] prodLowOut,
    output logic [$clog2(STACK_DEPTH)-1:0] stackDepth,
    output logic                          intBlock
);
    import sad_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    function automatic bit spTooWide(input int w);
        return (STAT_SP_LSB + w) > APB_DW;
    endfunction

    if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH
        || spTooWide(SP_W)) begin : g_bad_depth
        $error("STACK_DEPTH must be a power of two that fits the status word");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] top;
        logic [DATA_W-1:0] next;
        logic              carry;
        logic [DATA_W-1:0] prodHigh;
        logic [DATA_W-1:0] prodLow;
        logic [SP_W-1:0]   sp;
        logic              intBlock;
        logic              pready;
        logic              pslverr;
        logic [APB_DW-1:0] prdata;
    } sad_state_t;

    sad_state_t s_q;
    sad_state_t s_d;

    logic [DATA_W-1:0] stackMem [STACK_DEPTH];
    logic [DATA_W-1:0] popWord;
    logic [SP_W-1:0]   spDec;
    logic              pushEn;

    sad_shift_if shIf ();

    sad_shifter u_shifter (
        .sh (shIf)
    );

    // ------------------------------------------------------------------
    // ALU
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] aluRes;
    logic              aluCarry;
    logic [DATA_W:0]   aluWide;

    always_comb begin
        aluWide  = '0;
        aluRes   = s_q.top;
        aluCarry = s_q.carry;
        case (aluSel)
            ALU_T:   aluRes = s_q.top;
            ALU_AND: aluRes = s_q.top & s_q.next;
            ALU_OR:  aluRes = s_q.top | s_q.next;
            ALU_XOR: aluRes = s_q.top ^ s_q.next;
            ALU_N:   aluRes = s_q.next;
            ALU_ADD: begin
                aluWide  = {1'b0, s_q.top} + {1'b0, s_q.next};
                aluRes   = aluWide[DATA_W-1:0];
                aluCarry = aluWide[DATA_W];
            end
            ALU_NSUBT: begin
                aluWide  = {1'b0, s_q.next} + {1'b0, ~s_q.top} + 17'h00001;
                aluRes   = aluWide[DATA_W-1:0];
                aluCarry = aluWide[DATA_W];
            end
            ALU_TSUBN: begin
                aluWide  = {1'b0, s_q.top} + {1'b0, ~s_q.next} + 17'h00001;
                aluRes   = aluWide[DATA_W-1:0];
                aluCarry = aluWide[DATA_W];
            end
            default: aluRes = s_q.top;
        endcase
    end

    // ------------------------------------------------------------------
    // Operand routing into the shifter
    // ------------------------------------------------------------------
    logic isAlu;
    logic fromNext;
    logic nextGetsTop;
    logic isPop;
    logic isPush;
    logic isShiftOp;

    always_comb begin
        isAlu       = instOp inside {OP_ALU, OP_ALU_POP, OP_ALU_TTON, OP_PUSH_ALU};
        fromNext    = instOp inside {OP_NTOT_POP, OP_SWAP, OP_PUSH_SWAP, OP_NTOT};
        nextGetsTop = instOp inside {OP_TTON, OP_SWAP, OP_ALU_TTON,
                                     OP_PUSH_COPY, OP_PUSH_SWAP, OP_PUSH_ALU};
        isPop       = instOp inside {OP_INV_POP, OP_NTOT_POP, OP_ALU_POP};
        isPush      = instOp inside {OP_PUSH_COPY, OP_PUSH_SWAP, OP_PUSH_ALU};
        isShiftOp   = !(instOp inside {OP_UNSIGNED_PRODUCT_OP, OP_SIGNED_PRODUCT_OP, OP_RD_HIGH, OP_RD_LOW});

        if (isAlu) begin
            shIf.zIn = aluRes;
        end else if (fromNext) begin
            shIf.zIn = invert ? ~s_q.next : s_q.next;
        end else begin
            shIf.zIn = invert ? ~s_q.top : s_q.top;
        end
        shIf.nIn = nextGetsTop ? s_q.top : s_q.next;
        shIf.cIn = isAlu ? aluCarry : s_q.carry;
        shIf.sel = shiftSel;
    end

    // ------------------------------------------------------------------
    // Parameter stack memory
    // ------------------------------------------------------------------
    always_comb begin
        spDec   = s_q.sp - 1'b1;
        popWord = stackMem[spDec];
        pushEn  = instValid && isPush;
    end

    always_ff @(posedge clk) begin
        if (pushEn) begin
            stackMem[s_q.sp] <= s_q.next;
        end
    end

    // ------------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------------
    logic              apbAccess;
    logic              apbCommit;
    logic              addrOk;
    logic [APB_DW-1:0] readWord;

    always_comb begin
        apbAccess = psel && penable && !s_q.pready;
        apbCommit = psel && penable && s_q.pready && pwrite;
        addrOk    = 1'b1;
        readWord  = '0;
        case (paddr)
            ADDR_TOP:   readWord = APB_DW'(s_q.top);
            ADDR_NEXT:  readWord = APB_DW'(s_q.next);
            ADDR_PHIGH: readWord = APB_DW'(s_q.prodHigh);
            ADDR_PLOW:  readWord = APB_DW'(s_q.prodLow);
            ADDR_STAT: begin
                readWord[STAT_CARRY_BIT]         = s_q.carry;
                readWord[STAT_INTB_BIT]          = s_q.intBlock;
                readWord[STAT_SP_LSB +: SP_W]    = s_q.sp;
            end
            default:    addrOk = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic [PROD_W-1:0] prodU;
    logic [PROD_W-1:0] prodS;

    always_comb begin
        s_d   = s_q;
        prodU = s_q.top * s_q.next;
        prodS = PROD_W'($signed(s_q.top) * $signed(s_q.next));

        s_d.pready  = apbAccess;
        s_d.pslverr = apbAccess && !addrOk;
        s_d.prdata  = apbAccess ? readWord : '0;
        s_d.intBlock = instValid
            && (instOp inside {OP_UNSIGNED_PRODUCT_OP, OP_SIGNED_PRODUCT_OP, OP_RD_HIGH, OP_RD_LOW});

        if (instValid) begin
            if (isShiftOp) begin
                // For OP_INV_SHIFT, zero select and no complement leaves all unchanged
                s_d.top   = shIf.tOut;
                s_d.next  = shIf.nOut;
                s_d.carry = shIf.cOut;
                if (isPop) begin
                    s_d.next = popWord;
                    s_d.sp   = spDec;
                end
                if (isPush) begin
                    s_d.sp = s_q.sp + 1'b1;
                end
            end else begin
                case (instOp)
                    OP_UNSIGNED_PRODUCT_OP: begin
                        s_d.prodHigh = prodU[PROD_W-1:DATA_W];
                        s_d.prodLow  = prodU[DATA_W-1:0];
                    end
                    OP_SIGNED_PRODUCT_OP: begin
                        s_d.prodHigh = prodS[PROD_W-1:DATA_W];
                        s_d.prodLow  = prodS[DATA_W-1:0];
                    end
                    OP_RD_HIGH: begin
                        s_d.top  = s_q.prodHigh;
                        s_d.next = s_q.top;
                    end
                    OP_RD_LOW: begin
                        s_d.top  = s_q.prodLow;
                        s_d.next = s_q.top;
                    end
                    default: s_d.top = s_q.top;
                endcase
            end
        end else if (apbCommit) begin
            // Debug load of the stack registers when idle
            if (paddr == ADDR_TOP) begin
                s_d.top = pwdata[DATA_W-1:0];
            end
            if (paddr == ADDR_NEXT) begin
                s_d.next = pwdata[DATA_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q.top      <= WORD_RST;
            s_q.next     <= WORD_RST;
            s_q.carry    <= CARRY_RST;
            s_q.prodHigh <= WORD_RST;
            s_q.prodLow  <= WORD_RST;
            s_q.sp       <= '0;
            s_q.intBlock <= 1'b0;
            s_q.pready   <= 1'b0;
            s_q.pslverr  <= 1'b0;
            s_q.prdata   <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata      = s_q.prdata;
    assign pready      = s_q.pready;
    assign pslverr     = s_q.pslverr;
    assign topOut      = s_q.top;
    assign nextOut     = s_q.next;
    assign carryOut    = s_q.carry;
    assign prodHighOut = s_q.prodHigh;
    assign prodLowOut  = s_q.prodLow;
    assign stackDepth  = s_q.sp;
    assign intBlock    = s_q.intBlock;

endmodule

`default_nettype wire

/* bench/sad_dec_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sad_dec_model (
    input  wire logic                 issue,
    input  wire logic [12:0]          word,
    output var  logic                 instValid,
    output var  sad_pkg::sad_op_t     instOp,
    output var  sad_pkg::sad_alu_t    aluSel,
    output var  sad_pkg::sad_shift_t  shiftSel,
    output var  logic                 invert
);
    import sad_pkg::*;
    // Word split: variant, combine function, shift code, complement bit
    assign instValid = issue;
    assign instOp    = sad_op_t'(word[12:9]);
    assign aluSel    = sad_alu_t'(word[8:5]);
    assign shiftSel  = sad_shift_t'(word[4:1]);
    assign invert    = word[0];
endmodule

`default_nettype wire

/* bench/sad_stack_alu_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module sad_stack_alu_chk #(
    parameter int STACK_DEPTH = 16
) (
    input wire logic                           clk,
    input wire logic                           sys_rst,
    input wire logic                           instValid,
    input wire sad_pkg::sad_op_t               instOp,
    input wire sad_pkg::sad_shift_t            shiftSel,
    input wire logic                           invert,
    input wire logic [sad_pkg::DATA_W-1:0]     topOut,
    input wire logic [sad_pkg::DATA_W-1:0]     nextOut,
    input wire logic                           carryOut,
    input wire logic [sad_pkg::DATA_W-1:0]     prodHighOut,
    input wire logic [sad_pkg::DATA_W-1:0]     prodLowOut,
    input wire logic [$clog2(STACK_DEPTH)-1:0] stackDepth,
    input wire logic                           intBlock
);
    import sad_pkg::*;
    logic [PROD_W-1:0] uProd, sProd;
    logic              mulLike, isPush, isPop, isMul;
    assign uProd = {16'h0000, topOut} * {16'h0000, nextOut};
    assign sProd = {{DATA_W{topOut[MSB]}}, topOut} * {{DATA_W{nextOut[MSB]}}, nextOut};
    assign isMul = instValid && instOp inside {OP_UNSIGNED_PRODUCT_OP, OP_SIGNED_PRODUCT_OP};
    assign mulLike = isMul || (instValid && instOp inside {OP_RD_HIGH, OP_RD_LOW});
    assign isPush = instValid && instOp inside {OP_PUSH_COPY, OP_PUSH_SWAP, OP_PUSH_ALU};
    assign isPop = instValid && instOp inside {OP_INV_POP, OP_NTOT_POP, OP_ALU_POP};
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_unsigned_product_op_product: assert property (
        instValid && instOp == OP_UNSIGNED_PRODUCT_OP |=> {prodHighOut, prodLowOut} == $past(uProd))
        else $error("unsigned product wrong");
    chk_signed_product_op_product: assert property (
        instValid && instOp == OP_SIGNED_PRODUCT_OP |=> {prodHighOut, prodLowOut} == $past(sProd))
        else $error("signed product wrong");
    chk_mul_keeps_stack: assert property (
        isMul |=> $stable(topOut) && $stable(nextOut) && $stable(stackDepth))
        else $error("multiply disturbed stack");
    chk_int_block: assert property (intBlock == $past(mulLike))
        else $error("interrupt block mistimed");
    chk_read_high: assert property (
        instValid && instOp == OP_RD_HIGH |=> topOut == $past(prodHighOut)
            && nextOut == $past(topOut) && $stable(stackDepth))
        else $error("high product read wrong");
    chk_read_low: assert property (
        instValid && instOp == OP_RD_LOW |=> topOut == $past(prodLowOut)
            && nextOut == $past(topOut) && $stable(stackDepth))
        else $error("low product read wrong");
    chk_push_depth: assert property (isPush |=> stackDepth == $past(stackDepth) + 1'b1)
        else $error("push did not advance pointer");
    chk_pop_depth: assert property (isPop |=> stackDepth == $past(stackDepth) - 1'b1)
        else $error("pop did not retreat pointer");
    chk_nop_hold: assert property (
        instValid && instOp == OP_INV_SHIFT && !invert && shiftSel == SH_NONE
            |=> $stable(topOut) && $stable(nextOut) && $stable(carryOut))
        else $error("no-operation changed state");
    chk_top_to_next: assert property (
        instValid && !shiftSel[3] && instOp inside {OP_TTON, OP_SWAP, OP_ALU_TTON,
            OP_PUSH_COPY, OP_PUSH_SWAP, OP_PUSH_ALU} |=> nextOut == $past(topOut))
        else $error("old top not moved to next");
endmodule

bind sad_stack_alu sad_stack_alu_chk #(.STACK_DEPTH(STACK_DEPTH)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .instValid(instValid), .instOp(instOp),
    .shiftSel(shiftSel), .invert(invert), .topOut(topOut), .nextOut(nextOut),
    .carryOut(carryOut), .prodHighOut(prodHighOut), .prodLowOut(prodLowOut),
    .stackDepth(stackDepth), .intBlock(intBlock));

`default_nettype wire

/* bench/sad_stack_alu_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module sad_stack_alu_tb;
    import sad_pkg::*;
    logic              clk, rst, issue, instValid, invert, psel, penable, pwrite;
    logic              pready, pslverr, carryOut, intBlock, rC, cKnown, lastMul, e;
    logic [12:0]       word;
    sad_op_t           instOp;
    sad_alu_t          aluSel;
    sad_shift_t        shiftSel;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata, prdata, rd;
    logic [DATA_W-1:0] topOut, nextOut, prodHighOut, prodLowOut, rT, rN, rPh, rPl;
    logic [DATA_W-1:0] rStk [16];
    logic [3:0]        stackDepth, rSp;
    int                errors, nChecks, cycles;
    logic [31:0]       pairs [4] = '{32'hffffffff, 32'h80007fff, 32'h00030005, 32'h00001234};
    sad_shift_t        shs [9] = '{SH_LSR, SH_SHL, SH_NONE, SH_SIGN, SH_ASR, SH_NONE, SH_ROL,
                                   SH_CSHR, SH_CROR};

    sad_dec_model dec (.issue(issue), .word(word), .instValid(instValid), .instOp(instOp),
        .aluSel(aluSel), .shiftSel(shiftSel), .invert(invert));
    sad_stack_alu dut (.clk(clk), .sys_rst(rst), .instValid(instValid), .instOp(instOp),
        .aluSel(aluSel), .shiftSel(shiftSel), .invert(invert), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .topOut(topOut), .nextOut(nextOut),
        .carryOut(carryOut), .prodHighOut(prodHighOut), .prodLowOut(prodLowOut),
        .stackDepth(stackDepth), .intBlock(intBlock));

    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles > 5000) begin
            errors++;
            end_sim();
        end
    end

    task automatic cmp(logic [31:0] seen, logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic apb(logic wr, logic [APB_AW-1:0] a, logic [DATA_W-1:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic ld(logic [DATA_W-1:0] t, logic [DATA_W-1:0] n);
        apb(1'b1, ADDR_TOP, t);
        apb(1'b1, ADDR_NEXT, n);
        rT = t;
        rN = n;
    endtask

    task automatic rdc(logic [APB_AW-1:0] a, logic [31:0] x, logic xe);
        apb(1'b0, a, 16'h0000);
        cmp(rd, x);
        cmp(e, xe);
    endtask

    function automatic logic [DATA_W-1:0] aluF(sad_alu_t f, logic [DATA_W-1:0] t, n);
        case (f)
            ALU_AND:   return t & n;
            ALU_NSUBT: return n - t;
            ALU_OR:    return t | n;
            ALU_ADD:   return t + n;
            ALU_XOR:   return t ^ n;
            ALU_TSUBN: return t - n;
            ALU_N:     return n;
            default:   return t;
        endcase
    endfunction

    // Carry in the top bit, shifted operand below
    function automatic logic [DATA_W:0] shF(sad_shift_t s, logic [DATA_W-1:0] z, logic c);
        case (s)
            SH_SIGN: return {c, {16{z[15]}}};
            SH_SHL:  return {z[15], z[14:0], 1'b0};
            SH_ROL:  return {z, c};
            SH_CSHR: return {1'b0, c, z[15:1]};
            SH_CROR: return {z[0], c, z[15:1]};
            SH_LSR:  return {2'b00, z[15:1]};
            SH_ASR:  return {z[15], z[15], z[15:1]};
            default: return {c, z};
        endcase
    endfunction

    task automatic op(sad_op_t o, sad_alu_t f, sad_shift_t s, logic i);
        logic [DATA_W:0]   r;
        logic [DATA_W-1:0] z;
        logic              alu;
        alu = o inside {OP_ALU, OP_ALU_POP, OP_ALU_TTON, OP_PUSH_ALU};
        z = (o inside {OP_NTOT_POP, OP_SWAP, OP_PUSH_SWAP, OP_NTOT}) ? rN : rT;
        z = alu ? aluF(f, rT, rN) : (i ? ~z : z);
        r = shF(s, z, rC);
        lastMul = o inside {OP_UNSIGNED_PRODUCT_OP, OP_SIGNED_PRODUCT_OP, OP_RD_HIGH, OP_RD_LOW};
        if (!lastMul) begin
            rC = r[DATA_W];
            if (alu) cKnown = 1'b0;
            else if (s inside {[SH_SHL:SH_ASR]}) cKnown = 1'b1;
            if (o inside {OP_INV_POP, OP_NTOT_POP, OP_ALU_POP}) begin
                rSp--;
                rN = rStk[rSp];
            end else if (o inside {OP_PUSH_COPY, OP_PUSH_SWAP, OP_PUSH_ALU}) begin
                rStk[rSp] = rN;
                rSp++;
                rN = rT;
            end else if (o inside {OP_TTON, OP_SWAP, OP_ALU_TTON}) rN = rT;
            rT = r[DATA_W-1:0];
        end else if (o == OP_UNSIGNED_PRODUCT_OP) {rPh, rPl} = {16'h0000, rT} * {16'h0000, rN};
        else if (o == OP_SIGNED_PRODUCT_OP) {rPh, rPl} = {{16{rT[15]}}, rT} * {{16{rN[15]}}, rN};
        else begin
            rN = rT;
            rT = (o == OP_RD_HIGH) ? rPh : rPl;
        end
        issue <= 1'b1;
        word <= {o, f, s, i};
        @(posedge clk);
    endtask

    task automatic settle();
        issue <= 1'b0;
        @(negedge clk);
        cmp(topOut, rT);
        cmp(nextOut, rN);
        cmp(stackDepth, rSp);
        cmp({prodHighOut, prodLowOut}, {rPh, rPl});
        cmp(intBlock, lastMul);
        if (cKnown) cmp(carryOut, rC);
        @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        issue = 1'b0;
        word = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        {rT, rN, rPh, rPl, rSp, rC, lastMul} = '0;
        cKnown = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        settle();
        rdc(ADDR_STAT, 32'h0, 1'b0);
        $display("test reset done");
        for (int f = 0; f < 16; f++) begin
            ld(16'h8421, 16'h1f0f);
            op(OP_ALU, sad_alu_t'(f[3:0]), f[0] ? SH_SHL : SH_NONE, 1'b0);
            settle();
        end
        ld(16'hc3a5, 16'h0ff0);
        op(OP_INV_SHIFT, ALU_T, SH_NONE, 1'b0);
        settle();
        foreach (shs[k]) begin
            op(OP_INV_SHIFT, ALU_T, shs[k], k[0]);
            settle();
        end
        $display("test alu shift done");
        ld(16'h9234, 16'h5678);
        op(OP_PUSH_COPY, ALU_T, SH_SHL, 1'b1);
        settle();
        op(OP_PUSH_SWAP, ALU_T, SH_ASR, 1'b1);
        settle();
        op(OP_PUSH_ALU, ALU_XOR, SH_LSR, 1'b0);
        op(OP_INV_POP, ALU_T, SH_LSR, 1'b1);
        settle();
        op(OP_NTOT_POP, ALU_T, SH_SHL, 1'b1);
        op(OP_ALU_POP, ALU_TSUBN, SH_NONE, 1'b0);
        settle();
        op(OP_NTOT, ALU_T, SH_SHL, 1'b1);
        op(OP_TTON, ALU_T, SH_LSR, 1'b1);
        settle();
        op(OP_SWAP, ALU_T, SH_SHL, 1'b1);
        op(OP_ALU_TTON, ALU_NSUBT, SH_NONE, 1'b0);
        settle();
        $display("test stack done");
        foreach (pairs[k]) begin
            ld(pairs[k][31:16], pairs[k][15:0]);
            op(OP_UNSIGNED_PRODUCT_OP, ALU_T, SH_NONE, 1'b0);
            settle();
            op(OP_SIGNED_PRODUCT_OP, ALU_T, SH_NONE, 1'b0);
            op(OP_RD_HIGH, ALU_T, SH_NONE, 1'b0);
            settle();
            op(OP_RD_LOW, ALU_T, SH_NONE, 1'b0);
            settle();
        end
        $display("test multiply done");
        rdc(ADDR_PLOW, {16'h0000, rPl}, 1'b0);
        apb(1'b1, ADDR_PHIGH, 16'h5a5a);
        rdc(ADDR_PHIGH, {16'h0000, rPh}, 1'b0);
        rdc(8'h14, 32'h0, 1'b1);
        rdc(ADDR_TOP, {16'h0000, rT}, 1'b0);
        $display("test registers done");
        end_sim();
    end
endmodule

`default_nettype wire
